// ==== bench/mss_checker.sv ====
// concurrent checks on the load sequencer top ports
module mss_checker #(
  parameter int unsigned TENTH_CYCLES = mss_pkg::TENTH_CYCLES,
  parameter int unsigned FLASH_HALF_CYCLES = mss_pkg::FLASH_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [mss_pkg::NUM_OUT-1:0][mss_pkg::CNT_W-1:0] cfg_level,
  input wire logic [mss_pkg::CNT_W-1:0] cfg_max_count,
  input wire logic [mss_pkg::STEP_W-1:0] cfg_step_tenths,
  input wire logic [mss_pkg::CNT_W-1:0] seq_count,
  input wire logic [mss_pkg::NUM_OUT-1:0] load_enable,
  input wire logic [mss_pkg::NUM_OUT-1:0] fault_flash,
  input wire logic [mss_pkg::NUM_OUT-1:0] fault_active,
  input wire logic [mss_pkg::NUM_OUT-1:0] fault_open,
  input wire logic [mss_pkg::NUM_OUT-1:0] fault_overload,
  input wire logic master_indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [mss_pkg::CNT_W-1:0] max_eff;
  logic [mss_pkg::CNT_W-1:0] cnt_d_reg;
  logic [mss_pkg::STEP_W-1:0] step_eff;
  logic [mss_pkg::NUM_OUT-1:0] lvl_ok;
  logic [31:0] gap_reg;
  // ------
  // helpers
  // ------
  // zero settings mean defaults; step clamps at the top end
  assign max_eff = (cfg_max_count == 5'h00) ? mss_pkg::CNT_DEF_MAX : cfg_max_count;
  assign step_eff = (cfg_step_tenths == 13'h0000) ? mss_pkg::STEP_DEF_TENTHS :
    (cfg_step_tenths > mss_pkg::STEP_MAX_TENTHS) ? mss_pkg::STEP_MAX_TENTHS : cfg_step_tenths;
  always_comb begin
    for (int i = 0; i < mss_pkg::NUM_OUT; i++) begin
      lvl_ok[i] = cnt_d_reg >= ((cfg_level[i] == 5'h00) ? mss_pkg::LEVEL_MIN : cfg_level[i]);
    end
  end
  always_ff @(posedge clk_sys) begin
    cnt_d_reg <= seq_count;
  end
  // cycles since the last count change; reset counts as a fresh start
  always_ff @(posedge clk_sys) begin
    if (rst || seq_count != cnt_d_reg) begin
      gap_reg <= 32'h0000_0001;
    end else begin
      gap_reg <= gap_reg + 32'h0000_0001;
    end
  end
  // ------
  // checks
  // ------
  property p_one_level;
    seq_count != cnt_d_reg |-> seq_count == cnt_d_reg + 5'h01 || seq_count == cnt_d_reg - 5'h01;
  endproperty
  a_one_level: assert property (p_one_level) else $error("count jumped");
  property p_gap;
    seq_count != cnt_d_reg |-> gap_reg >= step_eff * TENTH_CYCLES;
  endproperty
  a_gap: assert property (p_gap) else $error("count step too early");
  property p_hold;
    seq_count <= max_eff;
  endproperty
  a_hold: assert property (p_hold) else $error("count above maximum");
  property p_ind;
    master_indicator == (cnt_d_reg != 5'h00);
  endproperty
  a_ind: assert property (p_ind) else $error("indicator wrong");
  property p_zero;
    cnt_d_reg == 5'h00 |-> load_enable == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("output on at zero");
  property p_level;
    (load_enable & ~lvl_ok) == '0;
  endproperty
  a_level: assert property (p_level) else $error("output below level");
  property p_fault_on;
    ((fault_open | fault_overload) & ~$past(load_enable)) == '0;
  endproperty
  a_fault_on: assert property (p_fault_on) else $error("load fault while off");
  property p_flash;
    (fault_flash & ~fault_active) == '0;
  endproperty
  a_flash: assert property (p_flash) else $error("flash without fault");
  c_full: cover property (seq_count == max_eff && master_indicator);
  c_flash: cover property (fault_flash != '0);
  c_drain: cover property ($fell(master_indicator));
endmodule

bind mss_sequencer_top mss_checker #(
  .TENTH_CYCLES(TENTH_CYCLES),
  .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)
) u_mss_checker (
  .clk_sys, .rst, .cfg_level, .cfg_max_count, .cfg_step_tenths, .seq_count, .load_enable,
  .fault_flash, .fault_active, .fault_open, .fault_overload, .master_indicator
);

// ==== bench/mss_power_model.sv ====
// power output module model: load current per output
module mss_power_model (
  input wire logic clk_sys,
  input wire logic [mss_pkg::NUM_OUT-1:0] load_enable,
  input wire logic [mss_pkg::NUM_OUT-1:0][1:0] load_mode,
  output logic [mss_pkg::NUM_OUT-1:0][mss_pkg::CUR_W-1:0] load_current
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // load
  // ------
  // mode 1 open lamp, 2 overload, else a good lamp; an off output draws nothing
  always @(negedge clk_sys) begin
    for (int i = 0; i < mss_pkg::NUM_OUT; i++) begin
      if (!load_enable[i]) begin
        load_current[i] <= 9'h000;
      end else begin
        case (load_mode[i])
          2'h1: load_current[i] <= 9'h005;
          2'h2: load_current[i] <= 9'h0fa;
          default: load_current[i] <= 9'h078;
        endcase
      end
    end
  end
endmodule

// ==== bench/tb.sv ====
// self-checking bench of the master switch load sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
  localparam int TC = 4;
  logic clk_sys, rst, master_switch, key_accessory, key_ignition, master_indicator;
  logic [3:0] load_switch, out_bad_status, load_enable, fault_flash;
  logic [3:0] fault_active, fault_open, fault_overload;
  logic [3:0][8:0] load_current;
  logic [3:0][1:0] load_mode;
  logic [4:0] cfg_max_count, seq_count;
  logic [12:0] cfg_step_tenths;
  logic [3:0][4:0] cfg_level;
  mss_pkg::mss_seq_state_t seq_state;
  logic [31:0] rnd;
  int err_total, n_compared, cnt_q;
  int cyc = 0;
  int stp[4] = '{1, 0, 3, 2};
  int mxc[4] = '{3, 0, 5, 4};
  mss_sequencer_top #(.TENTH_CYCLES(TC), .FLASH_HALF_CYCLES(3)) u_mss_sequencer_top (
    .clk_sys, .rst, .master_switch, .key_accessory, .key_ignition, .load_switch,
    .out_bad_status, .load_current, .cfg_max_count, .cfg_step_tenths, .cfg_level,
    .load_enable, .fault_flash, .fault_active, .fault_open, .fault_overload,
    .master_indicator, .seq_count, .seq_state
  );
  mss_power_model u_mss_power_model (.clk_sys, .load_enable, .load_mode, .load_current);
  // ------
  // model
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] exp_en(input int c);
    for (int i = 0; i < 4; i++) begin
      exp_en[i] = load_switch[i] && c >= ((cfg_level[i] == 0) ? 1 : cfg_level[i]);
    end
  endfunction
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc++;
  // every count change is judged against the run condition, then the outputs
  always begin
    @(negedge clk_sys);
    if (!rst && seq_count !== 5'(cnt_q)) begin
      `CHK("seq_count", 5'((master_switch && (key_accessory || key_ignition)) ? cnt_q + 1 : cnt_q - 1), seq_count)
      cnt_q = seq_count;
      repeat (2) @(negedge clk_sys);
      `CHK("load_enable", exp_en(cnt_q), load_enable)
    end
  end
  // ------
  // stimulus
  // ------
  task automatic run_round(input int r);
    int m, iv, t, mode;
    logic [3:0] ef;
    rnd = lfsr(rnd);
    mode = r % 3;
    cfg_step_tenths = 13'(stp[r]);
    cfg_max_count = 5'(mxc[r]);
    for (int i = 0; i < 4; i++) cfg_level[i] = 5'(rnd[3*i +: 3]);
    load_switch = rnd[15:12] | 4'h1;
    m = (mxc[r] == 0) ? 2 : mxc[r];
    iv = ((stp[r] == 0) ? 10 : stp[r]) * TC;
    repeat (4) @(negedge clk_sys);
    master_switch = 1'b1;
    key_accessory = r[0];
    key_ignition = !r[0];
    t = cyc;
    repeat (4) @(negedge clk_sys);
    `CHK("seq_state", mss_pkg::MSS_RAMP_UP, seq_state)
    for (int k = 0; k < 3000 && seq_count !== 5'(m); k++) @(negedge clk_sys);
    `CHK("ramp_up", 1'b1, cyc - t >= m * iv && cyc - t <= m * (iv + 3) + 8)
    repeat (2 * iv) @(negedge clk_sys);
    `CHK("seq_count", 5'(m), seq_count)
    `CHK("seq_state", mss_pkg::MSS_FULL, seq_state)
    load_switch = ~load_switch;
    repeat (6) @(negedge clk_sys);
    `CHK("load_enable", exp_en(m), load_enable)
    load_mode = {4{2'(mode)}};
    out_bad_status = (r == 3) ? 4'h4 : 4'h0;
    repeat (8) @(negedge clk_sys);
    ef = (mode != 0) ? exp_en(m) : 4'h0;
    `CHK("fault_open", (mode == 1) ? ef : 4'h0, fault_open)
    `CHK("fault_overload", (mode == 2) ? ef : 4'h0, fault_overload)
    ef = ef | out_bad_status;
    `CHK("fault_active", ef, fault_active)
    for (int k = 0; k < 12 && fault_flash === 4'h0; k++) @(negedge clk_sys);
    `CHK("fault_flash", ef != 4'h0, fault_flash !== 4'h0)
    load_mode = '0;
    out_bad_status = 4'h0;
    // drop the run condition by the keys in rounds 0 and 1, by the master switch in rounds 2 and 3
    if (r[1]) begin
      master_switch = 1'b0;
    end else begin
      key_accessory = 1'b0;
      key_ignition = 1'b0;
    end
    t = cyc;
    repeat (4) @(negedge clk_sys);
    `CHK("seq_state", mss_pkg::MSS_RAMP_DOWN, seq_state)
    for (int k = 0; k < 3000 && seq_count !== 5'h00; k++) @(negedge clk_sys);
    `CHK("ramp_down", 1'b1, cyc - t >= m * iv && cyc - t <= m * (iv + 3) + 8)
    repeat (3) @(negedge clk_sys);
    `CHK("load_enable", 4'h0, load_enable)
    `CHK("master_indicator", 1'b0, master_indicator)
    `CHK("seq_state", mss_pkg::MSS_OFF, seq_state)
  endtask
  initial begin
    rst = 1'b1;
    master_switch = 1'b0;
    key_accessory = 1'b0;
    key_ignition = 1'b0;
    load_switch = 4'h0;
    out_bad_status = 4'h0;
    load_mode = '0;
    cfg_max_count = 5'h00;
    cfg_step_tenths = 13'h0000;
    cfg_level = '0;
    rnd = 32'h0000_fb51;
    cnt_q = 0;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    `CHK("master_indicator", 1'b0, master_indicator)
    for (int r = 0; r < 4; r++) run_round(r);
    finish_test();
  end
  // a full run needs about seven hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
endmodule

// ==== src/mss_pkg.sv ====
// shared constants and types of the master switch load sequencer
package mss_pkg;

  // -------------------------------------------------------------------
  // widths
  // -------------------------------------------------------------------
  localparam int NUM_OUT = 4;
  localparam int CNT_W = 5;
  localparam int STEP_W = 13;
  localparam int CUR_W = 9;
  localparam int PRESC_W = 23;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TENTH_MS = 100;
  localparam int TENTH_CYCLES = TENTH_MS * (CLK_HZ / 1000);
  localparam int FLASH_HALF_MS = 125;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLK_HZ / 1000);

  // -------------------------------------------------------------------
  // configuration limits and defaults, step values in tenths of a second
  // -------------------------------------------------------------------
  localparam logic [STEP_W-1:0] STEP_MIN_TENTHS = 13'h0001;
  localparam logic [STEP_W-1:0] STEP_MAX_TENTHS = 13'h1770;
  localparam logic [STEP_W-1:0] STEP_DEF_TENTHS = 13'h000a;
  localparam logic [CNT_W-1:0] CNT_DEF_MAX = 5'h02;
  localparam logic [CNT_W-1:0] LEVEL_MIN = 5'h01;
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;

  // -------------------------------------------------------------------
  // load current limits, in tenths of an ampere
  // -------------------------------------------------------------------
  localparam logic [CUR_W-1:0] CUR_OVER_LIMIT = 9'h0c8;
  localparam logic [CUR_W-1:0] CUR_OPEN_LIMIT = 9'h00a;

  // -------------------------------------------------------------------
  // sequencer states
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    MSS_OFF,
    MSS_RAMP_UP,
    MSS_FULL,
    MSS_RAMP_DOWN
  } mss_seq_state_t;

endpackage

// ==== src/mss_sequencer_top.sv ====
// master switch load sequencer with per-output fault flashing
module mss_sequencer_top #(
  parameter int unsigned TENTH_CYCLES = mss_pkg::TENTH_CYCLES,
  parameter int unsigned FLASH_HALF_CYCLES = mss_pkg::FLASH_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic master_switch,
  input wire logic key_accessory,
  input wire logic key_ignition,
  input wire logic [mss_pkg::NUM_OUT-1:0] load_switch,
  input wire logic [mss_pkg::NUM_OUT-1:0] out_bad_status,
  input wire logic [mss_pkg::NUM_OUT-1:0][mss_pkg::CUR_W-1:0] load_current,
  input wire logic [mss_pkg::CNT_W-1:0] cfg_max_count,
  input wire logic [mss_pkg::STEP_W-1:0] cfg_step_tenths,
  input wire logic [mss_pkg::NUM_OUT-1:0][mss_pkg::CNT_W-1:0] cfg_level,
  output logic [mss_pkg::NUM_OUT-1:0] load_enable,
  output logic [mss_pkg::NUM_OUT-1:0] fault_flash,
  output logic [mss_pkg::NUM_OUT-1:0] fault_active,
  output logic [mss_pkg::NUM_OUT-1:0] fault_open,
  output logic [mss_pkg::NUM_OUT-1:0] fault_overload,
  output logic master_indicator,
  output logic [mss_pkg::CNT_W-1:0] seq_count,
  output mss_pkg::mss_seq_state_t seq_state
);

  localparam int N = mss_pkg::NUM_OUT;
  localparam int PIN_W = 3 + 2 * mss_pkg::NUM_OUT;

  // -------------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------------

  function automatic logic [mss_pkg::CNT_W-1:0] level_eff(
    input logic [mss_pkg::CNT_W-1:0] lvl
  );
    logic [mss_pkg::CNT_W-1:0] res;
    res = lvl;
    if (lvl < mss_pkg::LEVEL_MIN) begin
      res = mss_pkg::LEVEL_MIN;
    end
    return res;
  endfunction

  function automatic logic current_over(
    input logic [mss_pkg::CUR_W-1:0] cur
  );
    return cur > mss_pkg::CUR_OVER_LIMIT;
  endfunction

  function automatic logic current_open(
    input logic [mss_pkg::CUR_W-1:0] cur
  );
    return cur < mss_pkg::CUR_OPEN_LIMIT;
  endfunction

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic [N-1:0][mss_pkg::CUR_W-1:0] cur_meta_reg;
  logic [N-1:0][mss_pkg::CUR_W-1:0] cur_sync_reg;
  logic master_s;
  logic key_acc_s;
  logic key_ign_s;
  logic [N-1:0] switch_s;
  logic [N-1:0] bad_s;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {master_switch, key_accessory, key_ignition, load_switch, out_bad_status};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // current words are slow analog readings; a torn sample lasts one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_meta_reg <= '0;
      cur_sync_reg <= '0;
    end else begin
      cur_meta_reg <= load_current;
      cur_sync_reg <= cur_meta_reg;
    end
  end

  assign master_s = pin_sync_reg[PIN_W-1];
  assign key_acc_s = pin_sync_reg[PIN_W-2];
  assign key_ign_s = pin_sync_reg[PIN_W-3];
  assign switch_s = pin_sync_reg[2*N-1:N];
  assign bad_s = pin_sync_reg[N-1:0];

  // -------------------------------------------------------------------
  // shared configuration
  // -------------------------------------------------------------------
  logic [mss_pkg::CNT_W-1:0] max_eff;
  logic [mss_pkg::STEP_W-1:0] step_eff;

  always_comb begin
    max_eff = cfg_max_count;
    if (cfg_max_count == mss_pkg::CNT_RESET) begin
      max_eff = mss_pkg::CNT_DEF_MAX;
    end
  end

  always_comb begin
    step_eff = cfg_step_tenths;
    if (cfg_step_tenths == '0) begin
      step_eff = mss_pkg::STEP_DEF_TENTHS;
    end else if (cfg_step_tenths < mss_pkg::STEP_MIN_TENTHS) begin
      step_eff = mss_pkg::STEP_MIN_TENTHS;
    end else if (cfg_step_tenths > mss_pkg::STEP_MAX_TENTHS) begin
      step_eff = mss_pkg::STEP_MAX_TENTHS;
    end
  end

  // -------------------------------------------------------------------
  // step interval timer
  // -------------------------------------------------------------------
  mss_step_if step_bus ();
  logic run_now;
  logic run_prev_reg;

  assign run_now = master_s && (key_acc_s || key_ign_s);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= run_now;
    end
  end

  assign step_bus.interval_tenths = step_eff;
  // a reversal restarts the interval; a step already pending in the reversal cycle moves the count at once
  assign step_bus.restart = run_now != run_prev_reg;

  mss_step_timer #(
    .TENTH_CYCLES(TENTH_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(step_bus.timer)
  );

  // -------------------------------------------------------------------
  // sequence counter
  // -------------------------------------------------------------------
  logic [mss_pkg::CNT_W-1:0] count_reg;
  logic [mss_pkg::CNT_W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (step_bus.step) begin
      if (run_now && (count_reg < max_eff)) begin
        count_next = count_reg + 1'b1;
      end else if (run_now && (count_reg > max_eff)) begin
        // maximum lowered while running: walk down to it
        count_next = count_reg - 1'b1;
      end else if (!run_now && (count_reg != mss_pkg::CNT_RESET)) begin
        count_next = count_reg - 1'b1;
      end
    end
    // hold at maximum is the fall-through case
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= mss_pkg::CNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  assign seq_count = count_reg;

  // -------------------------------------------------------------------
  // sequencer state
  // -------------------------------------------------------------------
  mss_pkg::mss_seq_state_t state_reg;
  mss_pkg::mss_seq_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mss_pkg::MSS_OFF: begin
        if (run_now) begin
          state_next = mss_pkg::MSS_RAMP_UP;
        end
      end
      mss_pkg::MSS_RAMP_UP: begin
        if (!run_now) begin
          state_next = mss_pkg::MSS_RAMP_DOWN;
        end else if (count_next == max_eff) begin
          state_next = mss_pkg::MSS_FULL;
        end
      end
      mss_pkg::MSS_FULL: begin
        if (!run_now) begin
          state_next = mss_pkg::MSS_RAMP_DOWN;
        end else if (count_next != max_eff) begin
          state_next = mss_pkg::MSS_RAMP_UP;
        end
      end
      mss_pkg::MSS_RAMP_DOWN: begin
        if (run_now) begin
          state_next = mss_pkg::MSS_RAMP_UP;
        end else if (count_next == mss_pkg::CNT_RESET) begin
          state_next = mss_pkg::MSS_OFF;
        end
      end
      default: begin
        state_next = mss_pkg::MSS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= mss_pkg::MSS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign seq_state = state_reg;

  // -------------------------------------------------------------------
  // master indicator
  // -------------------------------------------------------------------

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      master_indicator <= 1'b0;
    end else begin
      master_indicator <= count_reg != mss_pkg::CNT_RESET;
    end
  end

  // -------------------------------------------------------------------
  // fast flash phase
  // -------------------------------------------------------------------
  logic [mss_pkg::PRESC_W-1:0] flash_cnt_reg;
  logic flash_phase_reg;
  logic flash_wrap;

  assign flash_wrap = flash_cnt_reg == mss_pkg::PRESC_W'(FLASH_HALF_CYCLES - 1);

  always_ff @(posedge clk_sys) begin
    if (rst || flash_wrap) begin
      flash_cnt_reg <= '0;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flash_phase_reg <= 1'b0;
    end else if (flash_wrap) begin
      flash_phase_reg <= !flash_phase_reg;
    end
  end

  // -------------------------------------------------------------------
  // per-output enable and diagnostics
  // -------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_out
      logic [mss_pkg::CNT_W-1:0] level;
      logic seq_ok;
      logic over_now;
      logic open_now;
      logic fault_now;

      assign level = level_eff(cfg_level[gi]);
      assign seq_ok = count_reg >= level;

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          load_enable[gi] <= 1'b0;
        end else begin
          load_enable[gi] <= seq_ok && switch_s[gi];
        end
      end

      // current checks only mean something while the output is driven
      // overload while on
      assign over_now = load_enable[gi] && current_over(cur_sync_reg[gi]);
      assign open_now = load_enable[gi] && current_open(cur_sync_reg[gi]);
      assign fault_now = bad_s[gi] || over_now || open_now;

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          fault_overload[gi] <= 1'b0;
          fault_open[gi] <= 1'b0;
        end else begin
          fault_overload[gi] <= over_now;
          fault_open[gi] <= open_now;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          fault_active[gi] <= 1'b0;
          fault_flash[gi] <= 1'b0;
        end else begin
          fault_active[gi] <= fault_now;
          fault_flash[gi] <= fault_now && flash_phase_reg;
        end
      end
    end
  endgenerate

endmodule

// ==== src/mss_step_if.sv ====
// step interval request and tick between sequencer and interval timer
interface mss_step_if;
  logic [mss_pkg::STEP_W-1:0] interval_tenths;
  logic restart;
  logic step;

  modport ctrl (
    output interval_tenths,
    output restart,
    input step
  );

  modport timer (
    input interval_tenths,
    input restart,
    output step
  );
endinterface

// ==== src/mss_step_timer.sv ====
// free-running step interval timer with restart
module mss_step_timer #(
  parameter int unsigned TENTH_CYCLES = mss_pkg::TENTH_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  mss_step_if.timer bus
);

  logic [mss_pkg::PRESC_W-1:0] presc_reg;
  logic [mss_pkg::STEP_W-1:0] tenth_reg;
  logic tenth_done;
  logic interval_done;

  // -------------------------------------------------------------------
  // tenth-second prescaler
  // -------------------------------------------------------------------
  assign tenth_done = (presc_reg == mss_pkg::PRESC_W'(TENTH_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || bus.restart || tenth_done) begin
      presc_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // tenths counted against the interval
  // -------------------------------------------------------------------
  assign interval_done = tenth_done && (tenth_reg >= bus.interval_tenths - 1'b1);

  always_ff @(posedge clk_sys) begin
    if (rst || bus.restart || interval_done) begin
      tenth_reg <= '0;
    end else if (tenth_done) begin
      tenth_reg <= tenth_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || bus.restart) begin
      bus.step <= 1'b0;
    end else begin
      bus.step <= interval_done;
    end
  end

endmodule
